// File: fcs_pkg.sv
// shared constants, types and pin carrier for the flash command sequencer
package fcs_pkg;

	// clock and pin timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_WE_PULSE_NS = 80;
	localparam int T_READ_ACC_NS = 120;
	localparam int T_RST_LOW_NS = 500;
	localparam int SYNC_STAGES = 2;
	localparam logic [7:0] WE_CYC =
		8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RD_CYC =
		8'((T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
	localparam logic [7:0] RST_CYC =
		8'((T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// flash bus geometry
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int SECT_LSB = 13;
	localparam logic [ADDR_W-1:0] UNLOCK_A = 18'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK_B = 18'h00aaa;
	localparam logic [SECT_LSB-1:0] PROT_OFS = 13'h0002;

	// command bytes
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;

	// status bits on the flash data lines
	localparam int POLL_STATUS_BIT = 7;
	localparam int TOGGLE_STATUS_BIT = 6;
	localparam int TIMEOUT_STATUS_BIT = 5;

	// own register map (byte addresses) and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_PINS = 8'h14;
	localparam int OP_W = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TMO = 2;
	localparam int ST_PAR = 3;
	localparam int ST_REF = 4;
	localparam int PIN_ID_HV = 0;
	localparam int PIN_UNPROT_HV = 1;

	// operations software can order
	typedef enum logic [OP_W-1:0] {
		OP_READ,
		OP_WRITE_RAW,
		OP_RESET1,
		OP_RESET4,
		OP_IDENT,
		OP_PROT_VERIFY,
		OP_PROGRAM,
		OP_CHIP_ERASE,
		OP_SECT_ERASE,
		OP_SUSPEND,
		OP_RESUME,
		OP_HW_RESET
	} fcs_op_e;

	// strobes, address and data lines toward the flash
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} fcs_pins_s;

	// one bus write of a command sequence
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcs_cyc_s;

endpackage

// File: fcs_bus_cycle.sv
// one read or write strobe cycle on the parallel flash pins
`timescale 1ns/10ps
`default_nettype none
module fcs_bus_cycle
	import fcs_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// request from the sequencer
	input wire logic i_go,
	input wire logic i_write,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_data,
	// flash data lines in
	input wire logic [DATA_W-1:0] i_dq,
	// answer and pins
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	output fcs_pins_s o_pins
);

	typedef enum logic [2:0] {
		E_IDLE,
		E_SETUP,
		E_STROBE,
		E_HOLD,
		E_END,
		E_READ
	} fcs_eng_e;

	typedef struct packed {
		fcs_eng_e st;
		logic write;
		logic [7:0] cnt;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
		logic [DATA_W-1:0] rdata;
		logic done;
		fcs_pins_s pins;
	} fcs_eng_s;

	fcs_eng_s r_ff;
	fcs_eng_s nxt_r;

	// strobe sequencer; the first sync stage feeds only the second
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;
		nxt_r.sync1 = i_dq;
		nxt_r.sync2 = r_ff.sync1;
		case (r_ff.st)
			E_IDLE:
			begin
				if (i_go)
				begin
					nxt_r.write = i_write;
					nxt_r.pins.addr = i_addr;
					nxt_r.pins.dq_out = i_data;
					nxt_r.pins.ce_n = 1'b0;
					nxt_r.pins.dq_oe = i_write;
					nxt_r.st = E_SETUP;
				end
			end
			E_SETUP:
			begin
				// address settles before the later falling strobe
				if (r_ff.write)
				begin
					nxt_r.pins.we_n = 1'b0;
					nxt_r.cnt = WE_CYC;
					nxt_r.st = E_STROBE;
				end
				else
				begin
					nxt_r.pins.oe_n = 1'b0;
					nxt_r.cnt = RD_CYC;
					nxt_r.st = E_READ;
				end
			end
			E_STROBE:
			begin
				if (r_ff.cnt == 8'h01)
				begin
					nxt_r.pins.we_n = 1'b1;
					nxt_r.st = E_HOLD;
				end
				else
				begin
					nxt_r.cnt = r_ff.cnt - 8'h01;
				end
			end
			E_HOLD:
			begin
				// data stays on past the first rising strobe
				nxt_r.pins.ce_n = 1'b1;
				nxt_r.st = E_END;
			end
			E_END:
			begin
				nxt_r.pins.dq_oe = 1'b0;
				nxt_r.done = 1'b1;
				nxt_r.st = E_IDLE;
			end
			E_READ:
			begin
				if (r_ff.cnt == 8'h01)
				begin
					nxt_r.rdata = r_ff.sync2;
					nxt_r.pins.oe_n = 1'b1;
					nxt_r.pins.ce_n = 1'b1;
					nxt_r.done = 1'b1;
					nxt_r.st = E_IDLE;
				end
				else
				begin
					nxt_r.cnt = r_ff.cnt - 8'h01;
				end
			end
			default:
			begin
				nxt_r.st = E_IDLE;
			end
		endcase
	end

	// state register; strobes idle high
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			r_ff <= '0;
			r_ff.pins.ce_n <= 1'b1;
			r_ff.pins.we_n <= 1'b1;
			r_ff.pins.oe_n <= 1'b1;
		end
		else
		begin
			r_ff <= nxt_r;
		end
	end

	assign o_done = r_ff.done;
	assign o_rdata = r_ff.rdata;
	assign o_pins = r_ff.pins;

endmodule
`default_nettype wire

// File: fcs_top.sv
// AHB-Lite controlled command sequencer for a byte-wide parallel flash
//
// Functional notes
// - raise address nine to identification voltage
// - write only with select, strobe low
// - hold reset pin low 500 ns minimum
// - read/reset by single or unlocked write
// - identification: unlock pair then 90h
// - program: unlock, A0h, then data byte
// - chip erase: six writes, then poll
// - sector erase ends 30h in sector
// - suspend B0h, resume 30h, any address
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fcs_top
	import fcs_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// flash pins
	input wire logic [DATA_W-1:0] i_dq,
	output fcs_pins_s o_pins,
	output logic o_flash_rst_n,
	output logic o_id_hv_en,
	output logic o_unprot_hv_en
);

	typedef enum logic [2:0] {
		M_IDLE,
		M_WRITE,
		M_READ,
		M_POLL,
		M_RST
	} fcs_main_e;

	typedef struct packed {
		fcs_main_e st;
		fcs_op_e op;
		logic [2:0] step;
		logic wait_c;
		logic [1:0] poll_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] prev;
		logic [7:0] cnt;
		logic rst_n;
		logic id_hv;
		logic unprot_hv;
		logic f_done;
		logic f_tmo;
		logic f_par;
		logic f_ref;
		logic cyc_go;
		logic cyc_wr;
		logic [ADDR_W-1:0] cyc_addr;
		logic [DATA_W-1:0] cyc_data;
		logic wr_pend;
		logic [7:0] reg_a;
		logic [31:0] hrdata;
	} fcs_top_s;

	fcs_top_s r_ff;
	fcs_top_s nxt_r;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;

	// number of bus writes in each ordered sequence
	function automatic logic [2:0] seq_len(input fcs_op_e op);
		case (op)
			OP_RESET4, OP_IDENT, OP_PROT_VERIFY: seq_len = 3'd3;
			OP_PROGRAM: seq_len = 3'd4;
			OP_CHIP_ERASE, OP_SECT_ERASE: seq_len = 3'd6;
			default: seq_len = 3'd1;
		endcase
	endfunction

	// address and data of write number idx of a sequence
	function automatic fcs_cyc_s seq_cycle(input fcs_op_e op,
		input logic [2:0] idx, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		fcs_cyc_s c;
		c.addr = UNLOCK_A;
		c.data = CMD_UNLOCK1;
		case (idx)
			3'd1, 3'd4:
			begin
				c.addr = UNLOCK_B;
				c.data = CMD_UNLOCK2;
			end
			3'd2:
			begin
				case (op)
					OP_RESET4: c.data = CMD_RESET;
					OP_IDENT, OP_PROT_VERIFY: c.data = CMD_IDENT;
					OP_PROGRAM: c.data = CMD_PROGRAM;
					default: c.data = CMD_ERASE_SETUP;
				endcase
			end
			3'd3:
			begin
				if (op == OP_PROGRAM)
				begin
					c.addr = a;
					c.data = d;
				end
			end
			3'd5:
			begin
				if (op == OP_SECT_ERASE)
				begin
					c.addr = a;
					c.data = CMD_SECT_ERASE;
				end
				else
				begin
					c.data = CMD_CHIP_ERASE;
				end
			end
			default:
			begin
				// single-write orders, all others open with unlock
				case (op)
					OP_WRITE_RAW:
					begin
						c.addr = a;
						c.data = d;
					end
					OP_RESET1:
					begin
						c.addr = a;
						c.data = CMD_RESET;
					end
					OP_SUSPEND:
					begin
						c.addr = a;
						c.data = CMD_SUSPEND;
					end
					OP_RESUME:
					begin
						c.addr = a;
						c.data = CMD_RESUME;
					end
					default: c.data = CMD_UNLOCK1;
				endcase
			end
		endcase
		seq_cycle = c;
	endfunction

	// register bus, sequencer and sticky flags in one pass
	always_comb
	begin
		logic busy;
		logic go;
		fcs_op_e go_op;
		logic [ST_REF:ST_DONE] clr;
		logic set_done;
		logic set_tmo;
		logic set_par;
		logic set_ref;
		fcs_cyc_s c;
		busy = (r_ff.st != M_IDLE);
		go = 1'b0;
		go_op = OP_READ;
		clr = '0;
		set_done = 1'b0;
		set_tmo = 1'b0;
		set_par = 1'b0;
		set_ref = 1'b0;
		c = '0;
		nxt_r = r_ff;
		nxt_r.cyc_go = 1'b0;

		// data phase of a write; orders refused while busy
		if (r_ff.wr_pend)
		begin
			case (r_ff.reg_a)
				REG_CTRL, REG_ADDR, REG_WDATA:
				begin
					if (busy)
					begin
						set_ref = 1'b1;
					end
					else if (r_ff.reg_a == REG_CTRL)
					begin
						go = 1'b1;
						go_op = fcs_op_e'(i_hwdata[OP_W-1:0]);
					end
					else if (r_ff.reg_a == REG_ADDR)
					begin
						nxt_r.addr = i_hwdata[ADDR_W-1:0];
					end
					else
					begin
						nxt_r.wdata = i_hwdata[DATA_W-1:0];
					end
				end
				REG_STATUS: clr = i_hwdata[ST_REF:ST_DONE];
				REG_PINS:
				begin
					nxt_r.id_hv = i_hwdata[PIN_ID_HV];
					nxt_r.unprot_hv = i_hwdata[PIN_UNPROT_HV];
				end
				default: nxt_r.id_hv = r_ff.id_hv;
			endcase
		end

		// address phase; read data registered for the data phase
		nxt_r.wr_pend = 1'b0;
		if (i_hsel && i_htrans[1] && i_hready)
		begin
			nxt_r.wr_pend = i_hwrite;
			nxt_r.reg_a = i_haddr[7:0];
			if (!i_hwrite)
			begin
				nxt_r.hrdata = '0;
				case (i_haddr[7:0])
					REG_CTRL: nxt_r.hrdata[OP_W-1:0] = r_ff.op;
					REG_ADDR: nxt_r.hrdata[ADDR_W-1:0] = r_ff.addr;
					REG_WDATA: nxt_r.hrdata[DATA_W-1:0] = r_ff.wdata;
					REG_STATUS:
					begin
						nxt_r.hrdata[ST_BUSY] = busy;
						nxt_r.hrdata[ST_DONE] = r_ff.f_done;
						nxt_r.hrdata[ST_TMO] = r_ff.f_tmo;
						nxt_r.hrdata[ST_PAR] = r_ff.f_par;
						nxt_r.hrdata[ST_REF] = r_ff.f_ref;
					end
					REG_RDATA: nxt_r.hrdata[DATA_W-1:0] = r_ff.rdata;
					REG_PINS:
					begin
						nxt_r.hrdata[PIN_ID_HV] = r_ff.id_hv;
						nxt_r.hrdata[PIN_UNPROT_HV] = r_ff.unprot_hv;
					end
					default: nxt_r.hrdata = '0;
				endcase
			end
		end

		// sequencer
		case (r_ff.st)
			M_IDLE:
			begin
				if (go)
				begin
					nxt_r.op = go_op;
					nxt_r.step = '0;
					nxt_r.wait_c = 1'b0;
					nxt_r.poll_n = '0;
					case (go_op)
						OP_READ: nxt_r.st = M_READ;
						OP_HW_RESET:
						begin
							nxt_r.rst_n = 1'b0;
							nxt_r.cnt = RST_CYC;
							nxt_r.st = M_RST;
						end
						OP_WRITE_RAW, OP_RESET1, OP_RESET4, OP_IDENT,
						OP_PROT_VERIFY, OP_PROGRAM, OP_CHIP_ERASE,
						OP_SECT_ERASE, OP_SUSPEND, OP_RESUME:
							nxt_r.st = M_WRITE;
						default: set_done = 1'b1;
					endcase
				end
			end
			M_WRITE:
			begin
				if (!r_ff.wait_c)
				begin
					c = seq_cycle(r_ff.op, r_ff.step, r_ff.addr,
						r_ff.wdata);
					nxt_r.cyc_go = 1'b1;
					nxt_r.cyc_wr = 1'b1;
					nxt_r.cyc_addr = c.addr;
					nxt_r.cyc_data = c.data;
					nxt_r.wait_c = 1'b1;
				end
				else if (cyc_done)
				begin
					nxt_r.wait_c = 1'b0;
					if (r_ff.step == seq_len(r_ff.op) - 3'd1)
					begin
						case (r_ff.op)
							OP_PROGRAM, OP_CHIP_ERASE, OP_SECT_ERASE,
							OP_SUSPEND, OP_RESUME:
								nxt_r.st = M_POLL;
							OP_IDENT, OP_PROT_VERIFY:
								nxt_r.st = M_READ;
							default:
							begin
								set_done = 1'b1;
								nxt_r.st = M_IDLE;
							end
						endcase
					end
					else
					begin
						nxt_r.step = r_ff.step + 3'd1;
					end
				end
			end
			M_READ:
			begin
				if (!r_ff.wait_c)
				begin
					nxt_r.cyc_go = 1'b1;
					nxt_r.cyc_wr = 1'b0;
					nxt_r.cyc_addr = r_ff.addr;
					if (r_ff.op == OP_PROT_VERIFY)
					begin
						nxt_r.cyc_addr = {r_ff.addr[ADDR_W-1:SECT_LSB],
							PROT_OFS};
					end
					nxt_r.wait_c = 1'b1;
				end
				else if (cyc_done)
				begin
					nxt_r.wait_c = 1'b0;
					nxt_r.rdata = cyc_rdata;
					if (r_ff.op == OP_IDENT && !(^cyc_rdata))
					begin
						set_par = 1'b1;
					end
					set_done = 1'b1;
					nxt_r.st = M_IDLE;
				end
			end
			M_POLL:
			begin
				// toggle compare between successive reads
				if (!r_ff.wait_c)
				begin
					nxt_r.cyc_go = 1'b1;
					nxt_r.cyc_wr = 1'b0;
					nxt_r.cyc_addr = r_ff.addr;
					nxt_r.wait_c = 1'b1;
				end
				else if (cyc_done)
				begin
					nxt_r.wait_c = 1'b0;
					nxt_r.prev = cyc_rdata;
					if (r_ff.poll_n == 2'd0)
					begin
						nxt_r.poll_n = 2'd1;
					end
					else if (cyc_rdata[TOGGLE_STATUS_BIT] ==
						r_ff.prev[TOGGLE_STATUS_BIT])
					begin
						nxt_r.rdata = cyc_rdata;
						set_done = 1'b1;
						nxt_r.st = M_IDLE;
					end
					else if (r_ff.poll_n == 2'd2)
					begin
						// still toggling after the limit bit: recover
						set_tmo = 1'b1;
						nxt_r.rdata = cyc_rdata;
						nxt_r.op = OP_RESET1;
						nxt_r.step = '0;
						nxt_r.st = M_WRITE;
					end
					else if (cyc_rdata[TIMEOUT_STATUS_BIT])
					begin
						nxt_r.poll_n = 2'd2;
					end
				end
			end
			M_RST:
			begin
				nxt_r.cnt = r_ff.cnt - 8'h01;
				if (r_ff.cnt == 8'h01)
				begin
					nxt_r.rst_n = 1'b1;
					set_done = 1'b1;
					nxt_r.st = M_IDLE;
				end
			end
			default: nxt_r.st = M_IDLE;
		endcase

		// sticky flags: a set in the clearing cycle wins
		nxt_r.f_done = (r_ff.f_done & ~clr[ST_DONE]) | set_done;
		nxt_r.f_tmo = (r_ff.f_tmo & ~clr[ST_TMO]) | set_tmo;
		nxt_r.f_par = (r_ff.f_par & ~clr[ST_PAR]) | set_par;
		nxt_r.f_ref = (r_ff.f_ref & ~clr[ST_REF]) | set_ref;
	end

	// state register
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			r_ff <= '0;
			r_ff.rst_n <= 1'b1;
		end
		else
		begin
			r_ff <= nxt_r;
		end
	end

	// pin-level strobe engine
	fcs_bus_cycle u_cycle (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_go(r_ff.cyc_go),
		.i_write(r_ff.cyc_wr),
		.i_addr(r_ff.cyc_addr),
		.i_data(r_ff.cyc_data),
		.i_dq(i_dq),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_pins(o_pins)
	);

	// zero-wait slave, always OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = r_ff.hrdata;
	assign o_flash_rst_n = r_ff.rst_n;
	assign o_id_hv_en = r_ff.id_hv;
	assign o_unprot_hv_en = r_ff.unprot_hv;

endmodule
`default_nettype wire

// File: fcs_top_sva.sv
// pin and bus answer assertions for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module fcs_chk
	import fcs_pkg::*;
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// watched outputs
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire fcs_pins_s o_pins,
	input wire logic o_flash_rst_n
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	logic [7:0] lo_ff;
	// length of a reset pulse; cleared while the pin is high
	always_ff @(posedge i_sys_clk)
		lo_ff <= (i_rst || o_flash_rst_n) ? 8'h00 : lo_ff + 8'h01;
	a_bus_okay: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready and okay");
	a_no_fight: assert property (o_pins.dq_oe |-> o_pins.oe_n)
		else $error("data driven while gate low");
	a_gate_read: assert property ($fell(o_pins.oe_n) |->
		!o_pins.ce_n && o_pins.we_n && !o_pins.dq_oe)
		else $error("read gate opened without select");
	a_gate_close: assert property ($rose(o_pins.oe_n) |-> o_pins.ce_n)
		else $error("select left low after read");
	a_write_qual: assert property (!o_pins.we_n |->
		!o_pins.ce_n && o_pins.oe_n && o_pins.dq_oe)
		else $error("write strobe without select");
	a_we_pulse: assert property ($fell(o_pins.we_n) |->
		##1 !o_pins.we_n ##1 o_pins.we_n)
		else $error("write strobe width wrong");
	a_lines_hold: assert property (!o_pins.we_n |->
		$stable(o_pins.addr) && $stable(o_pins.dq_out))
		else $error("lines moved under write strobe");
	a_ce_after_we: assert property ($rose(o_pins.we_n) |->
		!o_pins.ce_n ##1 o_pins.ce_n)
		else $error("select not held past strobe");
	a_rst_width: assert property ($rose(o_flash_rst_n) |->
		lo_ff == RST_CYC)
		else $error("flash reset pulse length wrong");
endmodule
bind fcs_top fcs_chk u_fcs_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_pins(o_pins),
	.o_flash_rst_n(o_flash_rst_n));
`default_nettype wire

// File: fcs_flash.sv
// behavioural byte-wide flash standing on the far side of the pins
`timescale 1ns/10ps
`default_nettype none
module fcs_flash
	import fcs_pkg::*;
#(
	parameter logic [4:0] PROT_SEC = 5'h03,
	// arbitrary identifier values, each of odd parity
	parameter logic [7:0] MK0 = 8'h51,
	parameter logic [7:0] MK1 = 8'h2a,
	parameter logic [7:0] PT0 = 8'h45,
	parameter logic [7:0] PT1 = 8'hd3
)
(
	// pins from the controller
	input wire fcs_pins_s i_pins,
	input wire logic i_rst_n,
	input wire logic i_id_hv,
	input wire logic i_unprot_hv,
	// data toward the controller and pulse check
	output logic [7:0] o_dq,
	output logic o_bad_rst
);
	logic [7:0] mem [0:262143];
	logic [17:0] al = 18'h0;
	logic [7:0] q = 8'h00, pd = 8'h00;
	logic idm = 1'b0, ers = 1'b0, hung = 1'b0, susp = 1'b0;
	logic tg = 1'b0, ok = 1'b0;
	int st = 0, busy = 0;
	realtime t0 = -1.0;
	wire rd_n = i_pins.ce_n | i_pins.oe_n;
	initial
	begin
		o_bad_rst = 1'b0;
		for (int i = 0; i < 262144; i++)
			mem[i] = 8'hff;
	end
	function automatic logic lk(input logic [17:0] a);
		return a[17:13] == PROT_SEC && !i_unprot_hv;
	endfunction
	function automatic logic [7:0] idv(input logic [17:0] a);
		if (a[1])
			return {7'h0, a[17:13] == PROT_SEC};
		return a[0] ? (a[8] ? PT1 : PT0) : (a[8] ? MK1 : MK0);
	endfunction
	// the zero pre-pass is invisible once the erase has run
	task automatic erase(input logic all, input logic [4:0] s);
		for (int i = 0; i < 262144; i++)
			if ((all || i[17:13] == s) && !lk(18'(i)))
				mem[i] = 8'hff;
		ers = 1'b1;
		busy = 4;
	endtask
	task automatic cmd(input logic [17:0] a, input logic [7:0] d);
		if (hung || busy > 0)
		begin
			// a running operation hears only reset, suspend, resume
			if (hung && d == CMD_RESET)
				hung = 1'b0;
			if (ers && d == CMD_SUSPEND)
				susp = 1'b1;
			if (ers && d == CMD_RESUME)
				susp = 1'b0;
		end
		else if (st == 3)
		begin
			st = 0;
			pd = d;
			ers = 1'b0;
			hung = |(d & ~mem[a]);
			busy = hung ? 0 : 3;
			if (!lk(a))
				mem[a] = mem[a] & d;
		end
		else if (st == 6)
		begin
			st = 0;
			if (d == CMD_CHIP_ERASE && a == UNLOCK_A)
				erase(1'b1, 5'h0);
			if (d == CMD_SECT_ERASE)
				erase(1'b0, a[17:13]);
		end
		else if (st == 2 && a == UNLOCK_A)
		begin
			st = d == CMD_PROGRAM ? 3 : d == CMD_ERASE_SETUP ? 4 : 0;
			if (d == CMD_IDENT)
				idm = 1'b1;
			if (d == CMD_RESET)
				idm = 1'b0;
		end
		else if (st == 1 || st == 5)
			st = (a == UNLOCK_B && d == CMD_UNLOCK2) ? st + 1 : 0;
		else
		begin
			if (st == 0 && d == CMD_RESET)
				idm = 1'b0;
			st = ((st == 0 || st == 4) && a == UNLOCK_A &&
				d == CMD_UNLOCK1) ? st + 1 : 0;
		end
	endtask
	// address on the later falling edge, data on the first rising one
	always @(negedge i_pins.we_n)
		al = i_pins.addr;
	always @(posedge i_pins.we_n)
		if (!i_pins.ce_n && i_pins.oe_n && i_rst_n)
			cmd(al, i_pins.dq_out);
	// status or data chosen at the gate, shown after an access delay
	always @(negedge rd_n)
	begin
		if ((hung || busy > 0) && !susp)
		begin
			tg = ~tg;
			q = {ers ? 1'b0 : ~pd[7], tg, hung, 5'h00};
			if (!hung)
				busy = busy - 1;
		end
		else if (idm || i_id_hv)
			q = idv(i_pins.addr);
		else
			q = mem[i_pins.addr];
		ok <= #60 1'b1;
	end
	always @(posedge rd_n)
		ok = 1'b0;
	// released lines show the inverse of the last value, not a hold
	assign o_dq = (!rd_n && ok) ? q : ~q;
	// hardware reset drops any operation; short pulses are flagged
	always @(negedge i_rst_n)
	begin
		t0 = $realtime;
		{hung, idm, susp, ers} = 4'h0;
		st = 0;
		busy = 0;
	end
	always @(posedge i_rst_n)
		o_bad_rst = o_bad_rst | (t0 >= 0 && $realtime - t0 < 500.0);
endmodule
`default_nettype wire

// File: test_flash_command_sequencer.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`default_nettype none
module test_flash_command_sequencer
	import fcs_pkg::*;
;
	logic i_sys_clk = 1'b0, i_rst = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0;
	logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, last;
	logic [1:0] i_htrans = 2'b00;
	logic o_hreadyout, o_hresp, o_flash_rst_n, o_id_hv_en, o_unprot_hv_en;
	logic bad, chk_dp = 1'b0;
	logic [7:0] fl_dq, i_dq, d, v;
	logic [7:0] idt [4] = '{8'h51, 8'h45, 8'h2a, 8'hd3};
	logic [31:0] expq [$];
	logic [31:0] lfsr = 32'hfb99;
	int fails = 0, checks = 0;
	fcs_pins_s o_pins;
	assign i_dq = o_pins.dq_oe ? o_pins.dq_out : fl_dq;
	fcs_top u_fcs_top (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
		.i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
		.i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_dq(i_dq),
		.o_pins(o_pins), .o_flash_rst_n(o_flash_rst_n),
		.o_id_hv_en(o_id_hv_en), .o_unprot_hv_en(o_unprot_hv_en));
	fcs_flash u_fcs_flash (.i_pins(o_pins), .i_rst_n(o_flash_rst_n),
		.i_id_hv(o_id_hv_en), .i_unprot_hv(o_unprot_hv_en),
		.o_dq(fl_dq), .o_bad_rst(bad));
	// 25 MHz clock
	initial
		forever #20 i_sys_clk = ~i_sys_clk;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hready is waited for under a bound, never assumed
	task automatic rdy;
		int n;
		n = 0;
		@(posedge i_sys_clk);
		while (o_hreadyout !== 1'b1 && n < 20)
		begin
			@(posedge i_sys_clk);
			n++;
		end
		if (n >= 20)
		begin
			fails++;
			wrap_up();
		end
	endtask
	// one single word transfer; ck marks a read to be compared
	task automatic bus(input logic w, ck, input logic [7:0] a,
		input logic [31:0] dd);
		i_hsel <= 1'b1;
		i_htrans <= 2'b10;
		i_hwrite <= w;
		i_haddr <= {24'h0, a};
		rdy();
		i_hsel <= 1'b0;
		i_htrans <= 2'b00;
		i_hwdata <= dd;
		chk_dp <= ck;
		rdy();
		last = o_hrdata;
		chk_dp <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dd);
		bus(1'b1, 1'b0, a, dd);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		expq.push_back(exp);
		bus(1'b0, 1'b1, a, 32'h0);
	endtask
	// order one operation, wait for done, check and clear the flags
	task automatic op(input logic [3:0] c, input logic [17:0] a,
		input logic [7:0] dd, input logic [31:0] st, input logic dbl);
		int n;
		wr(REG_ADDR, {14'h0, a});
		wr(REG_WDATA, {24'h0, dd});
		wr(REG_CTRL, {28'h0, c});
		if (dbl)
			wr(REG_CTRL, {28'h0, c});
		n = 0;
		last = 32'h0;
		while (last[ST_DONE] !== 1'b1 && n < 2000)
		begin
			bus(1'b0, 1'b0, REG_STATUS, 32'h0);
			n++;
		end
		if (n >= 2000)
		begin
			fails++;
			wrap_up();
		end
		rd(REG_STATUS, st);
		wr(REG_STATUS, 32'h1e);
	endtask
	// the monitor pairs each noted read with the oldest expectation
	always @(posedge i_sys_clk)
		if (chk_dp)
			cmp(o_hrdata, expq.pop_front());
	initial
	begin
		#4000000;
		fails++;
		wrap_up();
	end
	initial
	begin
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(posedge i_sys_clk);
		wr(8'h20, 32'hffffffff);
		for (int i = 0; i <= 32'h20; i += 4)
			rd(8'(i), 32'h0);
		op(OP_HW_RESET, 18'h0, 8'h0, 32'h2, 1'b0);
		cmp({31'h0, bad}, 32'h0);
		$display("registers and reset done");
		for (int i = 0; i < 4; i++)
		begin
			op(OP_IDENT, {9'h0, i[1], 7'h0, i[0]}, 8'h0, 32'h2, 1'b0);
			rd(REG_RDATA, {24'h0, idt[i]});
		end
		op(OP_READ, 18'h0, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, {24'h0, idt[0]});
		op(OP_PROT_VERIFY, 18'h06000, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, 32'h1);
		op(OP_IDENT, 18'h00002, 8'h0, 32'ha, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			op(OP_IDENT, 18'h0, 8'h0, 32'h2, 1'b0);
			op(i ? OP_RESET4 : OP_RESET1, 18'h0, 8'h0, 32'h2, 1'b0);
			op(OP_READ, 18'h0, 8'h0, 32'h2, 1'b0);
			rd(REG_RDATA, 32'hff);
		end
		wr(REG_PINS, 32'h1);
		rd(REG_PINS, 32'h1);
		op(OP_READ, 18'h00101, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, {24'h0, idt[3]});
		wr(REG_PINS, 32'h0);
		$display("identification done");
		lfsr = nx(lfsr);
		d = lfsr[7:0] & 8'hfe;
		lfsr = nx(lfsr);
		v = lfsr[7:0];
		op(OP_PROGRAM, 18'h02001, d, 32'h12, 1'b1);
		rd(REG_RDATA, {24'h0, d});
		op(OP_PROGRAM, 18'h01fff, v, 32'h2, 1'b0);
		op(OP_PROGRAM, 18'h02001, 8'hff, 32'h6, 1'b0);
		op(OP_READ, 18'h02001, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, {24'h0, d});
		op(OP_PROGRAM, 18'h06010, 8'h00, 32'h2, 1'b0);
		op(OP_READ, 18'h06010, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, 32'hff);
		wr(REG_PINS, 32'h2);
		op(OP_PROGRAM, 18'h06010, 8'h5a, 32'h2, 1'b0);
		wr(REG_PINS, 32'h0);
		$display("program done");
		op(OP_SECT_ERASE, 18'h06abc, 8'h0, 32'h2, 1'b0);
		op(OP_SECT_ERASE, 18'h03456, 8'h0, 32'h2, 1'b0);
		op(OP_READ, 18'h02001, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, 32'hff);
		op(OP_READ, 18'h01fff, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, {24'h0, v});
		op(OP_READ, 18'h06010, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, 32'h5a);
		op(OP_CHIP_ERASE, 18'h0, 8'h0, 32'h2, 1'b0);
		op(OP_READ, 18'h01fff, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, 32'hff);
		$display("erase done");
		op(OP_SUSPEND, 18'h0, 8'h0, 32'h2, 1'b0);
		op(OP_RESUME, 18'h0, 8'h0, 32'h2, 1'b0);
		op(4'hc, 18'h0, 8'h0, 32'h2, 1'b0);
		op(OP_WRITE_RAW, UNLOCK_A, CMD_UNLOCK1, 32'h2, 1'b0);
		op(OP_WRITE_RAW, UNLOCK_A, CMD_UNLOCK2, 32'h2, 1'b0);
		op(OP_WRITE_RAW, UNLOCK_A, CMD_IDENT, 32'h2, 1'b0);
		op(OP_READ, 18'h0, 8'h0, 32'h2, 1'b0);
		rd(REG_RDATA, 32'hff);
		$display("raw and idle commands done");
		wrap_up();
	end
endmodule
`default_nettype wire
